/* File: hdl/scmm_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module scmm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0]   count;
    logic          outValid;
    logic [WIDTH-1:0] outData;
  } scmm_fifo_s;

  scmm_fifo_s state;
  scmm_fifo_s next_state;
  logic [WIDTH-1:0] store [DEPTH];
  logic pushNow;
  logic popNow;

  // ready only reflects real room, so a stalled drain backs up the source
  assign inReady = (state.count != (PW+1)'(DEPTH));
  assign pushNow = inValid && inReady;
  assign popNow  = (state.count != '0) && (!state.outValid || outReady);
  assign outValid = state.outValid;
  assign outData  = state.outData;

  // pointer and output stage update
  always_comb begin
    next_state = state;
    if (pushNow) begin
      next_state.wrPtr = state.wrPtr + 1'b1;
    end
    if (outReady && state.outValid) begin
      next_state.outValid = 1'b0;
    end
    if (popNow) begin
      next_state.rdPtr    = state.rdPtr + 1'b1;
      next_state.outValid = 1'b1;
      next_state.outData  = store[state.rdPtr];
    end
    next_state.count = state.count + (PW+1)'(pushNow) - (PW+1)'(popNow);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // storage has no reset; only words behind count are ever read
  always_ff @(posedge clock) begin
    if (pushNow) begin
      store[state.wrPtr] <= inData;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/scmm_pkg.sv */
package scmm_pkg;

  // host bus geometry
  localparam int ADDR_W       = 12;
  localparam int DATA_W       = 16;
  localparam int MEMSEL_BIT   = 11;
  localparam int STREAM_HI    = 10;
  localparam int STREAM_LO    = 7;
  localparam int CHAN_HI      = 6;
  localparam int CHAN_LO      = 0;

  // register map
  localparam logic [11:0] CTRL_ADDR    = 12'h000;
  localparam logic [11:0] STATUS_ADDR  = 12'h001;
  localparam logic [11:0] OFFSET_BASE  = 12'h211;
  localparam logic [11:0] OFFSET_STEP  = 12'h002;
  localparam int          OFFSET_COUNT = 8;
  localparam logic [3:0]  OFFSET_FIRST = 4'h8;
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [11:0] OFFSET_RESET = 12'h000;
  localparam int          SEL_HI       = 2;
  localparam int          SEL_LO       = 0;
  localparam logic [2:0]  SEL_DATA_MEM = 3'h0;

  // connection word fields
  localparam int MODE_BIT  = 0;
  localparam int SRC_ST_HI = 11;
  localparam int SRC_ST_LO = 8;
  localparam int SRC_CH_HI = 7;
  localparam int SRC_CH_LO = 1;
  localparam int MSG_HI    = 10;
  localparam int MSG_LO    = 3;
  localparam int PCC_HI    = 2;
  localparam int PCC_LO    = 1;
  localparam logic [1:0] PCC_TRISTATE = 2'h0;
  localparam logic [1:0] PCC_MESSAGE  = 2'h1;
  localparam logic [1:0] PCC_BER      = 2'h2;

  // output offset fields
  localparam int OFF_CD_HI = 11;
  localparam int OFF_CD_LO = 5;
  localparam int OFF_BD_HI = 4;
  localparam int OFF_BD_LO = 2;
  localparam int OFF_FA_HI = 1;
  localparam int OFF_FA_LO = 0;

  localparam logic [14:0] PRBS_SEED  = 15'h7FFF;
  localparam logic [7:0]  IDLE_BYTE  = 8'hFF;
  localparam int          FIFO_DEPTH = 16;

  typedef struct packed {
    logic        csN;
    logic        dsN;
    logic        readNotWrite;
    logic [11:0] addr;
    logic [15:0] wdata;
  } scmm_hostbus_s;

  typedef struct packed {
    logic       valid;
    logic [3:0] stream;
    logic [6:0] channel;
    logic [7:0] data;
  } scmm_ingress_s;

  typedef struct packed {
    logic       drive;
    logic [3:0] stream;
    logic [6:0] slot;
    logic [2:0] bitDelay;
    logic [1:0] fraction;
    logic [7:0] data;
  } scmm_slot_s;

  localparam int SLOT_W = $bits(scmm_slot_s);

  typedef enum logic [1:0] {B_IDLE, B_READ1, B_READ2, B_ACK} scmm_bus_e;
  typedef enum logic [1:0] {S_CONN, S_DECODE, S_FORM, S_PUSH} scmm_sched_e;

endpackage

/* File: hdl/scmm_switch.sv */
`timescale 1ns/1ps
`default_nettype none
module scmm_switch
  import scmm_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          sys_rst,
  input  wire scmm_hostbus_s hostBus,
  output logic [15:0]        hostDataOut,
  output logic               hostDataOe,
  output logic               hostDtackN,
  input  wire scmm_ingress_s ingress,
  output logic               slotValid,
  input  wire logic          slotReady,
  output scmm_slot_s         slotData
);

  typedef struct packed {
    scmm_hostbus_s syncA;
    scmm_hostbus_s syncB;
    scmm_bus_e     bus;
    logic [11:0]   addr;
    logic          isRead;
    logic [15:0]   wdata;
    logic [15:0]   dataOut;
    logic          dataOe;
    logic          dtackN;
    logic [15:0]   ctrl;
    logic [OFFSET_COUNT-1:0][11:0] offset;
    scmm_sched_e   sched;
    logic [3:0]    outStream;
    logic [6:0]    outChan;
    logic [11:0]   connWord;
    logic [14:0]   prbs;
    scmm_slot_s    pending;
  } scmm_state_s;

  scmm_state_s state;
  scmm_state_s next_state;

  // memories: 16 streams x 128 channels each
  logic [7:0]  dataMem [2048];
  logic [11:0] connMem [2048];
  logic [7:0]  dmHostQ;
  logic [11:0] cmHostQ;
  logic [7:0]  dmSchedQ;
  logic [11:0] cmSchedQ;
  logic [10:0] dmSchedAddr;
  logic        hostDmWe;
  logic        hostCmWe;
  logic        fifoInReady;
  logic        fifoInValid;
  logic        strobe;
  logic        memSpace;
  logic        connSel;
  logic [10:0] hostIndex;
  logic [15:0] regRead;

  // only the second sync stage is looked at
  assign strobe    = !state.syncB.csN && !state.syncB.dsN;
  assign memSpace  = state.addr[MEMSEL_BIT];
  assign connSel   = (state.ctrl[SEL_HI:SEL_LO] != SEL_DATA_MEM);
  assign hostIndex = {state.addr[STREAM_HI:STREAM_LO],
                      state.addr[CHAN_HI:CHAN_LO]};

  assign hostDataOut = state.dataOut;
  assign hostDataOe  = state.dataOe;
  assign hostDtackN  = state.dtackN;
  assign fifoInValid = (state.sched == S_PUSH);

  // advance the error-test pattern by one byte
  function automatic logic [14:0] prbs_byte(input logic [14:0] seed);
    logic [14:0] s;
    s = seed;
    for (int i = 0; i < 8; i++) begin
      s = {s[13:0], s[14] ^ s[13]};
    end
    return s;
  endfunction

  // register read decode; unmapped addresses read as zero
  always_comb begin
    regRead = 16'h0000;
    if (state.addr == CTRL_ADDR) begin
      regRead = state.ctrl;
    end else if (state.addr == STATUS_ADDR) begin
      regRead = {3'h0, fifoInReady, state.outStream, 1'b0, state.outChan};
    end
    for (int i = 0; i < OFFSET_COUNT; i++) begin
      if (state.addr == OFFSET_BASE + 12'(i) * OFFSET_STEP) begin
        regRead = {4'h0, state.offset[i]};
      end
    end
  end

  // host bus sequencer and register writes
  always_comb begin
    next_state = state;
    hostDmWe = 1'b0;
    hostCmWe = 1'b0;
    next_state.syncA = hostBus;
    next_state.syncB = state.syncA;
    case (state.bus)
      B_IDLE: begin
        if (strobe) begin
          next_state.addr   = state.syncB.addr;
          next_state.isRead = state.syncB.readNotWrite;
          next_state.wdata  = state.syncB.wdata;
          next_state.bus    = state.syncB.readNotWrite ? B_READ1 : B_READ2;
        end
      end
      B_READ1: begin
        // memory read data registered this cycle
        next_state.bus = B_READ2;
      end
      B_READ2: begin
        if (state.isRead) begin
          if (memSpace) begin
            next_state.dataOut = connSel ? {4'h0, cmHostQ}
                                         : {8'h00, dmHostQ};
          end else begin
            next_state.dataOut = regRead;
          end
          next_state.dataOe = 1'b1;
        end else if (memSpace) begin
          hostCmWe = connSel;
          hostDmWe = !connSel;
        end else if (state.addr == CTRL_ADDR) begin
          next_state.ctrl = state.wdata;
        end else begin
          for (int i = 0; i < OFFSET_COUNT; i++) begin
            if (state.addr == OFFSET_BASE + 12'(i) * OFFSET_STEP) begin
              next_state.offset[i] = state.wdata[11:0];
            end
          end
        end
        next_state.dtackN = 1'b0;
        next_state.bus    = B_ACK;
      end
      B_ACK: begin
        // hold acknowledge until the host lets the strobe go
        if (!strobe) begin
          next_state.dtackN = 1'b1;
          next_state.dataOe = 1'b0;
          next_state.bus    = B_IDLE;
        end
      end
      default: begin
        next_state.bus = B_IDLE;
      end
    endcase

    // output scheduler: one output channel per pass
    // source taken from the word still in the read register, so the
    // data read lands on the same edge that latches the word
    dmSchedAddr = {cmSchedQ[SRC_ST_HI:SRC_ST_LO],
                   cmSchedQ[SRC_CH_HI:SRC_CH_LO]};
    case (state.sched)
      S_CONN: begin
        next_state.sched = S_DECODE;
      end
      S_DECODE: begin
        next_state.connWord = cmSchedQ;
        next_state.sched    = S_FORM;
      end
      S_FORM: begin
        next_state.pending.stream = state.outStream;
        next_state.pending.slot   = state.outChan;
        next_state.pending.bitDelay = 3'h0;
        next_state.pending.fraction = 2'h0;
        if (state.outStream >= OFFSET_FIRST) begin
          // channel delay shifts the slot, bit and fraction ride along
          next_state.pending.slot = state.outChan +
            state.offset[state.outStream[2:0]][OFF_CD_HI:OFF_CD_LO];
          next_state.pending.bitDelay =
            state.offset[state.outStream[2:0]][OFF_BD_HI:OFF_BD_LO];
          next_state.pending.fraction =
            state.offset[state.outStream[2:0]][OFF_FA_HI:OFF_FA_LO];
        end
        if (!state.connWord[MODE_BIT]) begin
          next_state.pending.drive = 1'b1;
          next_state.pending.data  = dmSchedQ;
        end else begin
          // per-channel control, no switched data here
          next_state.pending.drive = 1'b0;
          next_state.pending.data  = IDLE_BYTE;
          case (state.connWord[PCC_HI:PCC_LO])
            PCC_MESSAGE: begin
              next_state.pending.drive = 1'b1;
              next_state.pending.data  =
                state.connWord[MSG_HI:MSG_LO];
            end
            PCC_BER: begin
              next_state.pending.drive = 1'b1;
              next_state.pending.data  = state.prbs[7:0];
              next_state.prbs = prbs_byte(state.prbs);
            end
            default: begin
              // tristate and the reserved code both leave the line off
              next_state.pending.drive = 1'b0;
            end
          endcase
        end
        next_state.sched = S_PUSH;
      end
      S_PUSH: begin
        // stalls here while the buffer is full
        if (fifoInReady) begin
          next_state.outChan = state.outChan + 7'h01;
          if (state.outChan == 7'h7F) begin
            next_state.outStream = state.outStream + 4'h1;
          end
          next_state.sched = S_CONN;
        end
      end
      default: begin
        next_state.sched = S_CONN;
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= '0;
      state.syncA.csN <= 1'b1;
      state.syncA.dsN <= 1'b1;
      state.syncB.csN <= 1'b1;
      state.syncB.dsN <= 1'b1;
      state.bus    <= B_IDLE;
      state.sched  <= S_CONN;
      state.dtackN <= 1'b1;
      state.ctrl   <= CTRL_RESET;
      state.offset <= {OFFSET_COUNT{OFFSET_RESET}};
      state.prbs   <= PRBS_SEED;
    end else begin
      state <= next_state;
    end
  end

  // memory ports: registered reads, host and ingress writes
  always_ff @(posedge clock) begin
    dmHostQ  <= dataMem[hostIndex];
    cmHostQ  <= connMem[hostIndex];
    cmSchedQ <= connMem[{state.outStream, state.outChan}];
    dmSchedQ <= dataMem[dmSchedAddr];
    if (hostCmWe) begin
      connMem[hostIndex] <= state.wdata[11:0];
    end
    // host write goes last so it wins a same-address collision
    if (ingress.valid) begin
      dataMem[{ingress.stream, ingress.channel}] <= ingress.data;
    end
    if (hostDmWe) begin
      dataMem[hostIndex] <= state.wdata[7:0];
    end
  end

  scmm_fifo #(
    .WIDTH (SLOT_W),
    .DEPTH (FIFO_DEPTH)
  ) slotFifo (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (state.pending),
    .outValid (slotValid),
    .outReady (slotReady),
    .outData  (slotData)
  );

endmodule
`default_nettype wire

/* File: tb/scmm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module scmm_host_model
  import scmm_pkg::*;
(
  input  wire logic          clock,
  output var scmm_hostbus_s  hostBus,
  input  wire logic          hostDtackN,
  input  wire logic [15:0]   hostDataOut
);
  // bus idles deselected
  initial hostBus = '{1'b1, 1'b1, 1'b1, 12'hFFF, 16'hFFFF};

  // one strobed access, held until acknowledge is sampled low
  task automatic access(input logic rnw, input logic [11:0] a,
                        input logic [15:0] d, output logic [15:0] q,
                        output bit ok);
    int n;
    ok = 1'b0;
    q = 16'h0000;
    @(posedge clock);
    hostBus <= '{1'b0, 1'b0, rnw, a, d};
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge clock);
      if (hostDtackN === 1'b0) begin
        ok = 1'b1;
        q = hostDataOut;
      end
    end
    // released lines flip so nobody can lean on a stale value
    hostBus <= '{1'b1, 1'b1, rnw, ~a, ~d};
    // strobe stays high well past the three cycle minimum
    repeat (6) @(posedge clock);
  endtask
endmodule
`default_nettype wire

/* File: tb/scmm_switch_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module scmm_switch_sva
  import scmm_pkg::*;
(
  input wire logic          clock,
  input wire logic          sys_rst,
  input wire scmm_hostbus_s hostBus,
  input wire logic [15:0]   hostDataOut,
  input wire logic          hostDataOe,
  input wire logic          hostDtackN,
  input wire scmm_ingress_s ingress,
  input wire logic          slotValid,
  input wire logic          slotReady,
  input wire scmm_slot_s    slotData
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // host handshake: answer bounded by the two sync flops plus three cycles
  ack_latency_a: assert property (!hostBus.csN && $fell(hostBus.dsN)
    |-> ##[2:7] !hostDtackN) else $error("no acknowledge in time");
  ack_strobe_a: assert property ($fell(hostDtackN) |-> !hostBus.csN)
    else $error("acknowledge without strobe");
  ack_release_a: assert property (hostBus.csN [*4] |=> hostDtackN)
    else $error("acknowledge held after release");
  oe_acked_a: assert property (hostDataOe |-> !hostDtackN)
    else $error("data driven without acknowledge");
  oe_drop_a: assert property ($rose(hostDtackN) |-> !hostDataOe)
    else $error("data still driven after release");
  // slot stream: held under stall, idle byte when undriven
  slot_hold_a: assert property (slotValid && !slotReady
    |=> slotValid && $stable(slotData)) else $error("slot moved in stall");
  idle_byte_a: assert property (slotValid && !slotData.drive
    |-> slotData.data == IDLE_BYTE) else $error("undriven slot not idle");
  // low streams have no offset register, so their delays must be zero
  low_offset_a: assert property (slotValid && !slotData.stream[3]
    |-> slotData.bitDelay == 3'h0 && slotData.fraction == 2'h0)
    else $error("offset applied below stream 8");
  read_c: cover property (hostDataOe);
  stall_c: cover property (slotValid && !slotReady);
  idle_c: cover property (slotValid && !slotData.drive);
  high_c: cover property (slotValid && slotData.fraction == 2'h3);
endmodule
bind scmm_switch scmm_switch_sva u_scmm_switch_sva (.clock(clock),
  .sys_rst(sys_rst), .hostBus(hostBus), .hostDataOut(hostDataOut),
  .hostDataOe(hostDataOe), .hostDtackN(hostDtackN), .ingress(ingress),
  .slotValid(slotValid), .slotReady(slotReady), .slotData(slotData));
`default_nettype wire

/* File: tb/tb_scmm_switch.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_scmm_switch
  import scmm_pkg::*;
;
  logic          clock = 1'b0;
  logic          sys_rst = 1'b1;
  scmm_hostbus_s hostBus;
  logic [15:0]   hostDataOut;
  logic          hostDataOe;
  logic          hostDtackN;
  scmm_ingress_s ingress = '0;
  logic          slotValid;
  logic          slotReady = 1'b0;
  scmm_slot_s    slotData;
  logic          holdOff = 1'b0;
  logic [2:0]    stallCnt = 3'h0;
  logic [15:0]   lastRead;
  scmm_slot_s    got;
  int            num_errors = 0;
  int            n_compared = 0;
  int            i;
  logic [11:0]   cmAddr [7] = '{12'h800, 12'h801, 12'h802, 12'h803,
                                12'h804, 12'h805, 12'hC01};
  logic [11:0]   cmWord [7] = '{12'h512, 12'h52B, 12'h001, 12'h604,
                                12'h005, 12'h807, 12'h9E3};

  always #50 clock = ~clock;

  scmm_switch u_scmm_switch (.clock(clock), .sys_rst(sys_rst),
    .hostBus(hostBus), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
    .hostDtackN(hostDtackN), .ingress(ingress), .slotValid(slotValid),
    .slotReady(slotReady), .slotData(slotData));
  scmm_host_model u_scmm_host_model (.clock(clock), .hostBus(hostBus),
    .hostDtackN(hostDtackN), .hostDataOut(hostDataOut));

  // consumer takes seven slots in eight so the fifo sees back-pressure
  always @(posedge clock) begin
    stallCnt <= stallCnt + 3'h1;
    slotReady <= !holdOff && (stallCnt != 3'h0);
  end

  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic fail(input string msg);
    num_errors++;
    $display("wrong value at %0t: %s", $time, msg);
    print_verdict();
  endtask

  task automatic check(input logic [SLOT_W-1:0] g, input logic [SLOT_W-1:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    bit ok;
    u_scmm_host_model.access(1'b0, a, d, lastRead, ok);
    if (!ok) fail("write not acknowledged");
  endtask

  task automatic rdq(input logic [11:0] a);
    bit ok;
    u_scmm_host_model.access(1'b1, a, 16'h0000, lastRead, ok);
    if (!ok) fail("read not acknowledged");
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    rdq(a);
    check({9'h000, lastRead}, {9'h000, e});
  endtask

  // next accepted entry for one stream and output slot
  task automatic waitSlot(input logic [3:0] s, input logic [6:0] c);
    int n;
    bit hit;
    hit = 1'b0;
    for (n = 0; n < 40000 && !hit; n++) begin
      @(posedge clock);
      if (slotValid === 1'b1 && slotReady === 1'b1 &&
          slotData.stream === s && slotData.slot === c) begin
        hit = 1'b1;
        got = slotData;
      end
    end
    if (!hit) fail("slot never seen");
  endtask

  function automatic scmm_slot_s mk(input logic dr, input logic [3:0] st,
      input logic [6:0] sl, input logic [2:0] bd, input logic [1:0] fa,
      input logic [7:0] dt);
    return '{dr, st, sl, bd, fa, dt};
  endfunction

  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    // offset registers: reset value, reserved nibble reads zero
    for (i = 0; i < OFFSET_COUNT; i++) begin
      rd(OFFSET_BASE + 12'(2 * i), 16'h0000);
      wr(OFFSET_BASE + 12'(2 * i), 16'hFFFF);
      rd(OFFSET_BASE + 12'(2 * i), 16'h0FFF);
    end
    rd(12'h212, 16'h0000);
    wr(OFFSET_BASE, 16'h0FF7);
    $display("done registers");
    // data memory by host and by ingress
    wr(CTRL_ADDR, 16'h0000);
    wr(12'hA89, 16'h005A);
    ingress <= '{1'b1, 4'h6, 7'h02, 8'hC3};
    @(posedge clock);
    ingress.valid <= 1'b0;
    rd(12'hA89, 16'h005A);
    rd(12'hB02, 16'h00C3);
    $display("done data memory");
    // connection words for every mode
    wr(CTRL_ADDR, 16'h0001);
    rd(CTRL_ADDR, 16'h0001);
    for (i = 0; i < 7; i++) wr(cmAddr[i], {4'h0, cmWord[i]});
    for (i = 0; i < 7; i++) rd(cmAddr[i], {4'h0, cmWord[i]});
    $display("done connection memory");
    // stall until the fifo refuses, then drain
    holdOff <= 1'b1;
    repeat (120) @(posedge clock);
    rdq(STATUS_ADDR);
    check({24'h0, lastRead[12]}, 25'h0);
    holdOff <= 1'b0;
    waitSlot(4'h0, 7'h00);
    check(got, mk(1'b1, 4'h0, 7'h00, 3'h0, 2'h0, 8'h5A));
    waitSlot(4'h0, 7'h01);
    check(got, mk(1'b1, 4'h0, 7'h01, 3'h0, 2'h0, 8'hA5));
    waitSlot(4'h0, 7'h02);
    check(got, mk(1'b0, 4'h0, 7'h02, 3'h0, 2'h0, IDLE_BYTE));
    waitSlot(4'h0, 7'h03);
    check(got, mk(1'b1, 4'h0, 7'h03, 3'h0, 2'h0, 8'hC3));
    // first error-test byte since reset is the seed's low byte
    waitSlot(4'h0, 7'h04);
    check(got, mk(1'b1, 4'h0, 7'h04, 3'h0, 2'h0, PRBS_SEED[7:0]));
    waitSlot(4'h0, 7'h05);
    check(got, mk(1'b0, 4'h0, 7'h05, 3'h0, 2'h0, IDLE_BYTE));
    waitSlot(4'h8, 7'h00);
    check(got, mk(1'b1, 4'h8, 7'h00, 3'h5, 2'h3, 8'h3C));
    $display("done slot stream");
    // reset in mid-run brings registers back to their reset values
    sys_rst <= 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    rd(OFFSET_BASE, {4'h0, OFFSET_RESET});
    rd(CTRL_ADDR, CTRL_RESET);
    $display("done mid-run reset");
    print_verdict();
  end
endmodule
`default_nettype wire
